// ===== core/pmt_pkg.sv
// Package for the PHY transmit port: timing counts, buffer word layout.
// Assumes a single 40 MHz core clock; all pin inputs are asynchronous.
package pmt_pkg;

  // ==========================================================
  // Clocking
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TXCLK_FAST_HZ = 25_000_000;
  localparam int unsigned TXCLK_SLOW_HZ = 2_500_000;
  // Half periods round down, never below one cycle
  localparam int unsigned HALF_FAST_RAW = CLK_HZ / (2 * TXCLK_FAST_HZ);
  localparam int unsigned HALF_SLOW_RAW = CLK_HZ / (2 * TXCLK_SLOW_HZ);
  localparam logic [7:0] HALF_FAST =
    8'((HALF_FAST_RAW < 1) ? 1 : HALF_FAST_RAW);
  localparam logic [7:0] HALF_SLOW =
    8'((HALF_SLOW_RAW < 1) ? 1 : HALF_SLOW_RAW);

  // ==========================================================
  // Reset and crossover timing
  localparam int unsigned RESET_LOW_MS = 10;
  localparam longint unsigned RESET_LOW_CYC =
    (longint'(RESET_LOW_MS) * CLK_HZ + 999) / 1000;
  localparam int unsigned MDIX_WINDOW_US = 1000;
  localparam int unsigned MDIX_WINDOW_CYC =
    (MDIX_WINDOW_US * (CLK_HZ / 1_000_000));
  localparam int unsigned MDIX_CNT_W = 20;

  // ==========================================================
  // Synchroniser and data widths
  localparam int unsigned SYNC_W = 3;
  localparam int unsigned DATA_W = 4;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // ==========================================================
  // Word carried from the MAC port to the media side
  typedef struct packed {
    logic first;
    logic dibit;
    logic [DATA_W-1:0] data;
  } pmt_word_s;

endpackage : pmt_pkg

// ===== core/pmt_tx_port.sv
// PHY transmit port: MAC-facing MII/RMII transmit capture, transmit clock
// generation, media pair speed and crossover control.
// Assumes all pin inputs are asynchronous to clk and the MAC holds
// reset low long enough; the media side drains the buffer with ready.
`timescale 1ns/1ps

module pmt_tx_port #(
  parameter int unsigned MDIX_CYC = pmt_pkg::MDIX_WINDOW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Strap-like mode pins
  input wire logic rmiiMode,
  input wire logic speed100,
  input wire logic linkUp,
  input wire logic mdixEnable,
  // MAC transmit port
  input wire logic txEn,
  input wire logic [pmt_pkg::DATA_W-1:0] txData,
  input wire logic txClkI,
  output logic txClkO,
  output logic txClkOe,
  output logic macReady,
  // Media side stream
  output logic mediaValid,
  input wire logic mediaReady,
  output pmt_pkg::pmt_word_s mediaWord,
  // Pair configuration
  output logic pairSpeed100,
  output logic pairATransmit,
  output logic pairBTransmit
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [pmt_pkg::SYNC_W-1:0] enSy;
    logic [pmt_pkg::SYNC_W-1:0][pmt_pkg::DATA_W-1:0] dSy;
    logic [pmt_pkg::SYNC_W-1:0] refSy;
    logic [pmt_pkg::SYNC_W-1:0] rmiiSy;
    logic [pmt_pkg::SYNC_W-1:0] spdSy;
    logic [pmt_pkg::SYNC_W-1:0] linkSy;
    logic [pmt_pkg::SYNC_W-1:0] mdixSy;
    logic en;
    logic [pmt_pkg::DATA_W-1:0] data;
    logic refClk;
    logic rmii;
    logic s100;
    logic link;
    logic mdixEn;
    logic inFrame;
    logic [7:0] divCnt;
    logic txClk;
    logic [pmt_pkg::MDIX_CNT_W-1:0] mdixCnt;
    logic swap;
    logic [1:0] cnt;
    pmt_pkg::pmt_word_s buf0;
    pmt_pkg::pmt_word_s buf1;
  } pmt_state_s;

  localparam logic [pmt_pkg::MDIX_CNT_W-1:0] MDIX_LAST =
    pmt_pkg::MDIX_CNT_W'(MDIX_CYC - 1);

  pmt_state_s stateQ;
  pmt_state_s stateD;
  logic capture;
  logic push;
  logic pop;
  pmt_pkg::pmt_word_s inWord;

  // ==========================================================
  // Helpers
  function automatic logic [pmt_pkg::SYNC_W-1:0] shift1(
    logic [pmt_pkg::SYNC_W-1:0] s, logic in);
    return {s[pmt_pkg::SYNC_W-2:0], in};
  endfunction : shift1

  // A change counts only once the second and third stages agree
  function automatic logic settle(logic [pmt_pkg::SYNC_W-1:0] s,
    logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction : settle

  // ==========================================================
  // Next state
  always_comb begin
    logic [1:0] n;
    n = stateQ.cnt;
    stateD = stateQ;
    capture = 1'b0;
    inWord = '0;
    stateD.enSy = shift1(stateQ.enSy, txEn);
    stateD.refSy = shift1(stateQ.refSy, txClkI);
    stateD.rmiiSy = shift1(stateQ.rmiiSy, rmiiMode);
    stateD.spdSy = shift1(stateQ.spdSy, speed100);
    stateD.linkSy = shift1(stateQ.linkSy, linkUp);
    stateD.mdixSy = shift1(stateQ.mdixSy, mdixEnable);
    stateD.dSy = {stateQ.dSy[1:0], txData};
    stateD.en = settle(stateQ.enSy, stateQ.en);
    stateD.refClk = settle(stateQ.refSy, stateQ.refClk);
    stateD.rmii = settle(stateQ.rmiiSy, stateQ.rmii);
    stateD.s100 = settle(stateQ.spdSy, stateQ.s100);
    stateD.link = settle(stateQ.linkSy, stateQ.link);
    stateD.mdixEn = settle(stateQ.mdixSy, stateQ.mdixEn);
    if (stateQ.dSy[1] == stateQ.dSy[2]) begin
      stateD.data = stateQ.dSy[2];
    end

    // Transmit clock: 25 MHz cannot be reached from 40 MHz, so the fast
    // rate runs at the divider floor of one cycle per half period
    if (stateQ.rmii) begin
      stateD.divCnt = '0;
      stateD.txClk = 1'b0;
      // Reference clock is taken in; its rising edge times capture
      capture = stateQ.refClk & ~settle(stateQ.refSy, stateQ.refClk) ?
        1'b0 : (~stateQ.refClk & settle(stateQ.refSy, stateQ.refClk));
    end else if (stateQ.divCnt >= ((stateQ.s100 ? pmt_pkg::HALF_FAST
        : pmt_pkg::HALF_SLOW) - 8'h01)) begin
      stateD.divCnt = '0;
      stateD.txClk = ~stateQ.txClk;
      // Sample mid-bit, on our falling edge, clear of MAC transitions
      capture = stateQ.txClk;
    end else begin
      stateD.divCnt = stateQ.divCnt + 8'h01;
    end

    // Capture width follows the interface mode
    inWord.first = ~stateQ.inFrame;
    inWord.dibit = stateQ.rmii;
    inWord.data = stateQ.rmii ? {2'h0, stateQ.data[1:0]}
      : stateQ.data;
    push = capture & stateQ.en & (stateQ.cnt != pmt_pkg::BUF_DEPTH);
    pop = (stateQ.cnt != 2'h0) & mediaReady;
    if (capture) begin
      stateD.inFrame = stateQ.en;
    end

    // Two-entry buffer; head always in buf0
    begin
      if (pop) begin
        stateD.buf0 = stateQ.buf1;
        n = n - 2'h1;
      end
      if (push) begin
        if (n == 2'h0) begin
          stateD.buf0 = inWord;
        end else begin
          stateD.buf1 = inWord;
        end
        n = n + 2'h1;
      end
      stateD.cnt = n;
    end

    // Crossover hunt: swap roles each window until the link comes up
    if (!stateQ.mdixEn) begin
      stateD.swap = 1'b0;
      stateD.mdixCnt = '0;
    end else if (!stateQ.link) begin
      if (stateQ.mdixCnt >= MDIX_LAST) begin
        stateD.mdixCnt = '0;
        stateD.swap = ~stateQ.swap;
      end else begin
        stateD.mdixCnt = stateQ.mdixCnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  // ==========================================================
  // Outputs
  assign txClkO = stateQ.txClk;
  assign txClkOe = ~stateQ.rmii;
  assign macReady = stateQ.cnt != pmt_pkg::BUF_DEPTH;
  assign mediaValid = stateQ.cnt != 2'h0;
  assign mediaWord = stateQ.buf0;
  assign pairSpeed100 = stateQ.s100;
  assign pairATransmit = ~stateQ.swap;
  assign pairBTransmit = stateQ.swap;

  // ==========================================================
  // Checks
  chk_reset_clears_state: assert property (
    @(posedge clk) !rstn |-> (!mediaValid && !txClkO && !pairBTransmit))
    else $error("state not at default during reset");

  chk_idle_no_push: assert property (
    @(posedge clk) disable iff (!rstn)
    (!stateQ.en && !pop) |=> (stateQ.cnt == $past(stateQ.cnt)))
    else $error("word buffered while enable low");

  chk_enable_pushes: assert property (
    @(posedge clk) disable iff (!rstn)
    (capture && stateQ.en && stateQ.cnt == 2'h0) |=> mediaValid)
    else $error("valid data with enable high not buffered");

  chk_rmii_dibit: assert property (
    @(posedge clk) disable iff (!rstn)
    (push && stateQ.rmii && stateQ.cnt == 2'h0 && !pop)
      |=> (mediaWord.dibit && mediaWord.data[3:2] == 2'h0
        && mediaWord.data[1:0] == $past(stateQ.data[1:0])))
    else $error("rmii dibit not taken");

  chk_mii_nibble: assert property (
    @(posedge clk) disable iff (!rstn)
    (push && !stateQ.rmii && stateQ.cnt == 2'h0 && !pop)
      |=> (!mediaWord.dibit && mediaWord.data == $past(stateQ.data)))
    else $error("mii nibble not taken");

  chk_fast_clock: assert property (
    @(posedge clk) disable iff (!rstn || stateQ.rmii || !stateQ.s100)
    $rose(txClkO) |=> !txClkO ##1 txClkO)
    else $error("fast transmit clock half period wrong");

  chk_slow_clock: assert property (
    @(posedge clk) disable iff (!rstn || stateQ.rmii || stateQ.s100)
    $rose(txClkO) |-> txClkO[*8] ##1 !txClkO)
    else $error("slow transmit clock half period wrong");

  chk_pair_swap: assert property (
    @(posedge clk) disable iff (!rstn)
    (stateQ.mdixEn && !stateQ.link && stateQ.mdixCnt >= MDIX_LAST)
      |=> (pairATransmit != $past(pairATransmit)) && !pairBTransmit
        == pairATransmit)
    else $error("pair roles not swapped at window end");

  // The reference clock is an input in this mode, so the pin stays quiet
  chk_rmii_clock_off: assert property (
    @(posedge clk) disable iff (!rstn)
    stateQ.rmii |=> !txClkO)
    else $error("transmit clock toggles in rmii mode");

endmodule : pmt_tx_port

// ===== sim/pmt_mac_model.sv
// MAC transmit model: sends four units per frame on the TX clock.
// Assumes clk is fast enough to see every TX clock edge.
`timescale 1ns/1ps
module pmt_mac_model (
  // Clocking
  input wire logic clk,
  input wire logic rmiiMode,
  input wire logic txClkO,
  input wire logic txClkI,
  // Frame control
  input wire logic go,
  input wire logic [15:0] pat,
  output logic done,
  // MAC pins
  output logic txEn,
  output logic [3:0] txData
);
  logic clkQ;
  int n;
  initial begin
    txEn = 1'b0;
    txData = 4'h0;
    clkQ = 1'b0;
    n = 0;
  end
  assign done = (n == 4) && !txEn;
  // Only a rising TX clock moves the pins
  always @(posedge clk) begin
    clkQ <= rmiiMode ? txClkI : txClkO;
    if ((rmiiMode ? txClkI : txClkO) && !clkQ) begin
      if (go && n < 4) begin
        txEn <= 1'b1;
        if (rmiiMode) txData <= {2'h3, pat[2*n+:2]};
        else txData <= pat[4*n+:4];
        n <= n + 1;
      end else begin
        // Idle lines churn so a leak into the buffer shows
        txEn <= 1'b0;
        txData <= ~txData;
        if (!go) n <= 0;
      end
    end
  end
endmodule : pmt_mac_model

// ===== sim/tb_pmt_tx_port.sv
// Testbench for the PHY transmit port with a MAC model.
// Assumes a 40 MHz clk and a free-running 200 ns reference clock.
`timescale 1ns/1ps
module tb_pmt_tx_port;
  logic clk, rstn, rmiiMode, speed100, linkUp, mdixEnable, txEn, txClkI;
  logic txClkO, txClkOe, macReady, mediaValid, mediaReady, go, done;
  logic pairSpeed100, pairATransmit, pairBTransmit;
  logic [3:0] txData;
  logic [15:0] pat;
  pmt_pkg::pmt_word_s mediaWord;
  pmt_pkg::pmt_word_s got[$];
  int errTotal, nCompared, cycles;
  pmt_tx_port #(.MDIX_CYC(16)) u_pmt_tx_port (.clk(clk), .rstn(rstn),
    .rmiiMode(rmiiMode), .speed100(speed100), .linkUp(linkUp),
    .mdixEnable(mdixEnable), .txEn(txEn), .txData(txData),
    .txClkI(txClkI), .txClkO(txClkO), .txClkOe(txClkOe),
    .macReady(macReady), .mediaValid(mediaValid),
    .mediaReady(mediaReady), .mediaWord(mediaWord),
    .pairSpeed100(pairSpeed100), .pairATransmit(pairATransmit),
    .pairBTransmit(pairBTransmit));
  pmt_mac_model u_pmt_mac_model (.clk(clk), .rmiiMode(rmiiMode),
    .txClkO(txClkO), .txClkI(txClkI), .go(go), .pat(pat), .done(done),
    .txEn(txEn), .txData(txData));
  // ==========================================================
  // Clocks, monitor, timeout
  always #12.5 clk = ~clk;
  initial begin
    txClkI = 1'b0;
    #37;
    forever #100 txClkI = ~txClkI;
  end
  always @(posedge clk) begin
    if (mediaValid === 1'b1 && mediaReady === 1'b1) got.push_back(mediaWord);
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      endOfTest();
    end
  end
  // ==========================================================
  // Helpers
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : endOfTest
  task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
    nCompared++;
    if (exp !== seen) begin
      errTotal++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic setMode(logic r, logic s);
    rmiiMode = r;
    speed100 = s;
    cyc(8);
  endtask : setMode
  // ==========================================================
  // Scenarios
  task automatic tReset();
    chk("pairA", 8'h1, pairATransmit);
    chk("pairB", 8'h0, pairBTransmit);
    chk("clkOe", 8'h1, txClkOe);
    chk("ready", 8'h1, macReady);
    chk("valid", 8'h0, mediaValid);
  endtask : tReset
  task automatic tClock(logic s, logic [7:0] half);
    int h, l, k;
    setMode(1'b0, s);
    chk("speed", 8'(s), pairSpeed100);
    for (k = 0; k < 40 && txClkO !== 1'b0; k++) cyc(1);
    for (k = 0; k < 40 && txClkO !== 1'b1; k++) cyc(1);
    for (h = 0; h < 40 && txClkO === 1'b1; h++) cyc(1);
    for (l = 0; l < 40 && txClkO === 1'b0; l++) cyc(1);
    chk("clkHigh", half, 8'(h));
    chk("clkLow", half, 8'(l));
  endtask : tClock
  task automatic sendFrame();
    int k;
    got.delete();
    go = 1'b1;
    for (k = 0; k < 600 && done !== 1'b1; k++) cyc(1);
    go = 1'b0;
    cyc(20);
  endtask : sendFrame
  task automatic tFrame(logic r, logic s);
    setMode(r, s);
    chk("clkOe", 8'(!r), txClkOe);
    pat = 16'h9C63;
    sendFrame();
    chk("count", 8'h4, 8'(got.size()));
    for (int k = 0; k < 4 && k < got.size(); k++) begin
      chk("word", r ? {2'h0, k == 0, 3'h4, pat[2*k+:2]}
        : {2'h0, k == 0, 1'b0, pat[4*k+:4]}, 8'(got[k]));
    end
  endtask : tFrame
  task automatic tStall();
    setMode(1'b0, 1'b0);
    mediaReady = 1'b0;
    pat = 16'h5AF0;
    sendFrame();
    chk("full", 8'h0, macReady);
    chk("held", 8'h1, mediaValid);
    mediaReady = 1'b1;
    cyc(6);
    chk("drain", 8'h2, 8'(got.size()));
    chk("w0", 8'h20, 8'(got[0]));
    chk("w1", 8'h0F, 8'(got[1]));
    chk("empty", 8'h1, macReady);
  endtask : tStall
  task automatic tMdix();
    int k, g;
    logic a;
    mdixEnable = 1'b1;
    linkUp = 1'b0;
    cyc(8);
    a = pairATransmit;
    for (k = 0; k < 60 && pairATransmit === a; k++) cyc(1);
    for (g = 0; g < 60 && pairATransmit !== a; g++) cyc(1);
    chk("gap", 8'h1, 8'(g >= 16 && g <= 17));
    chk("pairs", {7'h00, ~pairATransmit}, pairBTransmit);
    linkUp = 1'b1;
    cyc(8);
    a = pairATransmit;
    cyc(60);
    chk("hold", 8'(a), pairATransmit);
    mdixEnable = 1'b0;
    cyc(8);
    chk("noSwap", 8'h1, pairATransmit);
  endtask : tMdix
  task automatic tMidReset();
    int k;
    mediaReady = 1'b0;
    mdixEnable = 1'b1;
    linkUp = 1'b0;
    pat = 16'h1234;
    sendFrame();
    for (k = 0; k < 60 && pairBTransmit !== 1'b1; k++) cyc(1);
    chk("preValid", 8'h1, mediaValid);
    chk("prePairB", 8'h1, pairBTransmit);
    rstn = 1'b0;
    cyc(20);
    chk("rstValid", 8'h0, mediaValid);
    chk("rstPairB", 8'h0, pairBTransmit);
    chk("rstReady", 8'h1, macReady);
    chk("rstClk", 8'h0, txClkO);
    rstn = 1'b1;
    cyc(2);
    chk("relValid", 8'h0, mediaValid);
    chk("relPairA", 8'h1, pairATransmit);
    mediaReady = 1'b1;
    mdixEnable = 1'b0;
    linkUp = 1'b1;
    cyc(8);
  endtask : tMidReset
  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {rmiiMode, speed100, mdixEnable, go} = 4'h0;
    linkUp = 1'b1;
    mediaReady = 1'b1;
    pat = 16'h0000;
    errTotal = 0;
    nCompared = 0;
    cycles = 0;
    // Far shorter than the pin minimum; the logic resets asynchronously, with no clock edge
    cyc(20);
    tReset();
    rstn = 1'b1;
    cyc(8);
    tClock(1'b0, pmt_pkg::HALF_SLOW);
    tClock(1'b1, pmt_pkg::HALF_FAST);
    tFrame(1'b0, 1'b0);
    tFrame(1'b0, 1'b1);
    tFrame(1'b1, 1'b0);
    tStall();
    tMdix();
    tMidReset();
    endOfTest();
  end
endmodule : tb_pmt_tx_port
